// *** hw/channel_timer_array.sv ***
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "ctc_consts.svh"
// Operation
// - Sixteen channels, each selects its time base and capture or compare.
// - Two independent 16-bit time base counters, each with a reload register.
// - Counter clock chosen from prescaled system clock or auxiliary timer overflow.
// - Each time base can be clocked by its own external count input.
// - One-cycle resolution normally; eight cycles in staggered mode.
// - Each channel owns one pin: capture trigger or compare output.
// - Capture copies the assigned time base and raises the channel interrupt.
// - Capture edge selectable: rising, falling or both.
// - Compare channels match continuously against their time base.
// - Compare mode 0 interrupts on every match, pin untouched.
// - Compare mode 1 toggles the pin on every match.
// - Compare mode 2 interrupts at most once per timer period.
// - Compare mode 3 sets pin on match, clears on overflow, once per period.
// - Double register mode: two channels toggle one shared pin.
// - Single event option stops a channel after its first compare action.
// - Auxiliary timer six overflow is routed in as a count source.
// - Each source has request, enable; software may set the request.
module channel_timer_array import ctc_pkg::*; #(
  parameter int NCH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Channel pins
  input wire logic [NCH-1:0] i_ch_pin,
  output logic [NCH-1:0] o_ch_pin,
  output logic [NCH-1:0] o_ch_pin_oe,
  // Count sources
  input wire logic [1:0] i_ext_count,
  input wire logic i_aux_timer_six_ovf,
  // Interrupt
  output logic o_irq
);
  timebase_if tb0();
  timebase_if tb1();

  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0] tcfg_q [2];
  logic [15:0] trel_q [2];
  logic stag_q;
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_en_q;
  ch_cfg_s cfg_q [NCH];
  logic [15:0] val_q [NCH];
  logic [NCH-1:0] pin_q;
  logic [NCH-1:0] match_w;
  logic [NCH-1:0] chan_evt;
  logic [NCH-1:0] pin_rise;
  logic [NCH-1:0] pin_fall;
  logic [1:0] ext_rise;

  // Bus decode; one wait state gives a registered read path
  wire acc = i_avs_read | i_avs_write;
  wire wr_go = i_avs_write & ack_q;
  wire [7:0] addr = {i_avs_address[7:2], 2'b00};
  wire [3:0] ch_idx = addr[5:2];
  wire cfg_hit = (addr & `OFS_CH_MASK) == `OFS_CH_CFG;
  wire val_hit = (addr & `OFS_CH_MASK) == `OFS_CH_VAL;
  wire [15:0] wd16 = i_avs_writedata[15:0];
  wire [`IRQ_W-1:0] wd_irq = i_avs_writedata[`IRQ_W-1:0];
  wire [`IRQ_W-1:0] irq_set = (wr_go && addr == `OFS_IRQ_SET) ? wd_irq : '0;
  wire [`IRQ_W-1:0] irq_clr = (wr_go && addr == `OFS_IRQ_CLR) ? wd_irq : '0;
  wire [`IRQ_W-1:0] irq_evt = {tb1.ovf, tb0.ovf, chan_evt};

  assign o_avs_waitrequest = acc & ~ack_q;
  assign o_avs_readdata = rdata_q;

  always_comb begin
    rdata_d = 32'h00000000;
    if (cfg_hit) begin
      rdata_d = {26'h0, cfg_q[ch_idx]};
    end else if (val_hit) begin
      rdata_d = {16'h0000, val_q[ch_idx]};
    end else begin
      case (addr)
        `OFS_TCFG0: rdata_d = {28'h0000000, tcfg_q[0]};
        `OFS_TCFG1: rdata_d = {28'h0000000, tcfg_q[1]};
        `OFS_TCNT0: rdata_d = {16'h0000, tb0.count};
        `OFS_TCNT1: rdata_d = {16'h0000, tb1.count};
        `OFS_TREL0: rdata_d = {16'h0000, trel_q[0]};
        `OFS_TREL1: rdata_d = {16'h0000, trel_q[1]};
        `OFS_STAG: rdata_d = {31'h0, stag_q};
        `OFS_IRQ_STAT: rdata_d = {14'h0, irq_stat_q};
        `OFS_IRQ_EN: rdata_d = {14'h0, irq_en_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= acc & ~ack_q;
      if (i_avs_read && !ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tcfg_q[0] <= 4'h0;
      tcfg_q[1] <= 4'h0;
      trel_q[0] <= `RST_WORD;
      trel_q[1] <= `RST_WORD;
      stag_q <= 1'b0;
      irq_en_q <= '0;
    end else if (wr_go) begin
      case (addr)
        `OFS_TCFG0: tcfg_q[0] <= i_avs_writedata[3:0];
        `OFS_TCFG1: tcfg_q[1] <= i_avs_writedata[3:0];
        `OFS_TREL0: trel_q[0] <= wd16;
        `OFS_TREL1: trel_q[1] <= wd16;
        `OFS_STAG: stag_q <= i_avs_writedata[0];
        `OFS_IRQ_EN: irq_en_q <= wd_irq;
        default: stag_q <= stag_q;
      endcase
    end
  end

  // Hardware events and software set both beat a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt | irq_set;
    end
  end

  assign o_irq = |(irq_stat_q & irq_en_q);

  pin_sync #(.W(NCH)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pins(i_ch_pin),
    .o_level(),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  pin_sync #(.W(2)) u_ext_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pins(i_ext_count),
    .o_level(),
    .o_rise(ext_rise),
    .o_fall()
  );

  timebase u_tb0 (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_src(clk_src_e'(tcfg_q[0][`CFG_SRC_LSB +: 3])),
    .i_run(tcfg_q[0][`CFG_RUN_BIT]),
    .i_stag(stag_q),
    .i_reload(trel_q[0]),
    .i_aux_ovf(i_aux_timer_six_ovf),
    .i_ext_rise(ext_rise[0]),
    .i_wr(wr_go && addr == `OFS_TCNT0),
    .i_wdata(wd16),
    .o_tb(tb0)
  );

  timebase u_tb1 (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_src(clk_src_e'(tcfg_q[1][`CFG_SRC_LSB +: 3])),
    .i_run(tcfg_q[1][`CFG_RUN_BIT]),
    .i_stag(stag_q),
    .i_reload(trel_q[1]),
    .i_aux_ovf(i_aux_timer_six_ovf),
    .i_ext_rise(ext_rise[1]),
    .i_wr(wr_go && addr == `OFS_TCNT1),
    .i_wdata(wd16),
    .o_tb(tb1)
  );

  for (genvar n = 0; n < NCH; n++) begin : g_ch
    localparam int P = n ^ 8;
    logic armed_q;
    logic done_q;
    wire ch_cfg_s c = cfg_q[n];
    wire cfg_wr = wr_go & cfg_hit & (ch_idx == 4'(n));
    wire val_wr = wr_go & val_hit & (ch_idx == 4'(n));
    wire [15:0] tcnt = c.tsel ? tb1.count : tb0.count;
    wire tupd = c.tsel ? tb1.upd : tb0.upd;
    wire tovf = c.tsel ? tb1.ovf : tb0.ovf;
    wire m_rise = (c.mode == CAP_RISE) | (c.mode == CAP_BOTH);
    wire m_fall = (c.mode == CAP_FALL) | (c.mode == CAP_BOTH);
    wire cap = (m_rise & pin_rise[n]) | (m_fall & pin_fall[n]);
    wire live = ~done_q;
    wire once = (c.mode == CMP_IRQ_ONCE) | (c.mode == CMP_SET_ONCE);
    wire act_all = live & match_w[n] & (c.mode == CMP_IRQ_ALL);
    wire tog_own = match_w[n] & (c.mode == CMP_TOGGLE);
    wire tog_dbl = (match_w[n] | match_w[P]) & (c.mode == CMP_DOUBLE);
    wire act_tog = live & (tog_own | tog_dbl);
    wire act_once = live & armed_q & match_w[n] & once;
    wire act_set = act_once & (c.mode == CMP_SET_ONCE);

    // Match only on a fresh count value, so one value gives one event
    assign match_w[n] = tupd & (tcnt == val_q[n]);
    assign chan_evt[n] = cap | act_all | act_tog | act_once;
    assign o_ch_pin[n] = pin_q[n];
    assign o_ch_pin_oe[n] = (c.mode == CMP_TOGGLE) | (c.mode == CMP_SET_ONCE) |
                            (c.mode == CMP_DOUBLE);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cfg_q[n] <= ch_cfg_s'(`CH_CFG_W'(0));
        val_q[n] <= `RST_WORD;
        pin_q[n] <= 1'b0;
        armed_q <= 1'b1;
        done_q <= 1'b0;
      end else begin
        if (cfg_wr) begin
          cfg_q[n] <= ch_cfg_s'(i_avs_writedata[`CH_CFG_W-1:0]);
        end
        // A capture wins over a software write in the same cycle
        if (cap) begin
          val_q[n] <= tcnt;
        end else if (val_wr) begin
          val_q[n] <= wd16;
        end
        if (act_set) begin
          pin_q[n] <= 1'b1;
        end else if (tovf && c.mode == CMP_SET_ONCE) begin
          pin_q[n] <= 1'b0;
        end else if (act_tog) begin
          pin_q[n] <= ~pin_q[n];
        end
        if (act_once) begin
          armed_q <= 1'b0;
        end else if (tovf || cfg_wr) begin
          armed_q <= 1'b1;
        end
        if (cfg_wr) begin
          done_q <= 1'b0;
        end else if (c.single && (act_all || act_tog || act_once)) begin
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule

// *** hw/ctc_consts.svh ***
`ifndef CTC_CONSTS_SVH
`define CTC_CONSTS_SVH

`define OFS_TCFG0 8'h00
`define OFS_TCFG1 8'h04
`define OFS_TCNT0 8'h08
`define OFS_TCNT1 8'h0C
`define OFS_TREL0 8'h10
`define OFS_TREL1 8'h14
`define OFS_STAG 8'h18
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_CLR 8'h24
`define OFS_IRQ_EN 8'h28
`define OFS_IRQ_SET 8'h2C
`define OFS_CH_CFG 8'h40
`define OFS_CH_VAL 8'h80
`define OFS_CH_MASK 8'hC0

`define CFG_SRC_LSB 0
`define CFG_RUN_BIT 3
`define CH_CFG_W 6
`define IRQ_TOV0_BIT 16
`define IRQ_TOV1_BIT 17
`define IRQ_W 18

`define STAG_PHASE_LAST 3'h7
`define RST_WORD 16'h0000
`define PRESC_W 5

`endif

// *** hw/ctc_pkg.sv ***
package ctc_pkg;

  typedef enum logic [3:0] {
    CH_OFF,
    CAP_RISE,
    CAP_FALL,
    CAP_BOTH,
    CMP_IRQ_ALL,
    CMP_TOGGLE,
    CMP_IRQ_ONCE,
    CMP_SET_ONCE,
    CMP_DOUBLE
  } ch_mode_e;

  typedef enum logic [2:0] {
    SRC_DIV1,
    SRC_DIV2,
    SRC_DIV4,
    SRC_DIV8,
    SRC_DIV16,
    SRC_DIV32,
    SRC_AUX_OVF,
    SRC_EXT
  } clk_src_e;

  typedef struct packed {
    logic single;
    logic tsel;
    ch_mode_e mode;
  } ch_cfg_s;

endpackage

// *** hw/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Asynchronous pins
  input wire logic [W-1:0] i_pins,
  // Synchronous view
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign o_level = s2_q;
  assign o_rise = s2_q & ~s3_q;
  assign o_fall = ~s2_q & s3_q;
endmodule

// *** hw/timebase.sv ***
`timescale 1ns/1ps
`include "ctc_consts.svh"
module timebase import ctc_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Configuration
  input wire clk_src_e i_src,
  input wire logic i_run,
  input wire logic i_stag,
  input wire logic [15:0] i_reload,
  // Count sources
  input wire logic i_aux_ovf,
  input wire logic i_ext_rise,
  // Software load
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  // Time base out
  timebase_if.src o_tb
);
  logic [`PRESC_W-1:0] presc_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic upd_q;
  logic ovf_q;
  logic sel_tick;
  logic tick;
  logic wrap;

  function automatic logic div_tick(input logic [`PRESC_W-1:0] p, input int k);
    logic [`PRESC_W-1:0] mask;
    mask = `PRESC_W'((1 << k) - 1);
    return &(p | ~mask);
  endfunction

  always_comb begin
    case (i_src)
      SRC_DIV1: sel_tick = 1'b1;
      SRC_DIV2: sel_tick = div_tick(presc_q, 1);
      SRC_DIV4: sel_tick = div_tick(presc_q, 2);
      SRC_DIV8: sel_tick = div_tick(presc_q, 3);
      SRC_DIV16: sel_tick = div_tick(presc_q, 4);
      SRC_DIV32: sel_tick = div_tick(presc_q, 5);
      SRC_AUX_OVF: sel_tick = i_aux_ovf;
      SRC_EXT: sel_tick = i_ext_rise;
      default: sel_tick = 1'b0;
    endcase
  end

  // Staggered mode lets the counter step only every eighth cycle
  assign tick = i_run & sel_tick & (~i_stag | (presc_q[2:0] == `STAG_PHASE_LAST));
  assign wrap = tick & (&count_q);
  assign count_d = i_wr ? i_wdata : wrap ? i_reload : tick ? count_q + 16'h0001 : count_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_q <= '0;
      count_q <= `RST_WORD;
      upd_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      presc_q <= presc_q + `PRESC_W'(1);
      count_q <= count_d;
      upd_q <= tick | i_wr;
      ovf_q <= wrap & ~i_wr;
    end
  end

  assign o_tb.count = count_q;
  assign o_tb.upd = upd_q;
  assign o_tb.ovf = ovf_q;
endmodule

// *** hw/timebase_if.sv ***
`timescale 1ns/1ps
interface timebase_if;
  logic [15:0] count;
  logic upd;
  logic ovf;
  modport src (output count, output upd, output ovf);
  modport sink (input count, input upd, input ovf);
endinterface

// *** tb/channel_timer_array_checker.sv ***
`timescale 1ns/1ps
module channel_timer_array_checker #(
  parameter int NCH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Pins and interrupt
  input wire logic [NCH-1:0] o_ch_pin,
  input wire logic [NCH-1:0] o_ch_pin_oe,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire req = i_avs_read | i_avs_write;
  wire wr_acc = i_avs_write & ~o_avs_waitrequest;
  sequence s_first; req && o_avs_waitrequest; endsequence
  sequence s_ack; req && !o_avs_waitrequest; endsequence
  property p_wait_first; $rose(req) |-> o_avs_waitrequest; endproperty
  property p_wait_one; s_first |=> !o_avs_waitrequest; endproperty
  property p_wait_idle; !req |-> !o_avs_waitrequest; endproperty
  property p_wait_again; s_ack ##1 req |-> o_avs_waitrequest; endproperty
  property p_rd_load;
    $changed(o_avs_readdata) |-> $past(i_avs_read && o_avs_waitrequest);
  endproperty
  property p_oe_cfg; $changed(o_ch_pin_oe) |-> $past(wr_acc); endproperty
  // A pin moves only while its channel owns it
  property p_pin_owned;
    ((o_ch_pin ^ $past(o_ch_pin)) & ~(o_ch_pin_oe | $past(o_ch_pin_oe))) == '0;
  endproperty
  property p_irq_fall; $fell(o_irq) |-> $past(wr_acc); endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  a_wait_one: assert property (p_wait_one) else $error("wait state too long");
  a_wait_idle: assert property (p_wait_idle) else $error("wait while idle");
  a_wait_again: assert property (p_wait_again) else $error("no wait on next request");
  a_rd_load: assert property (p_rd_load) else $error("read data moved");
  a_oe_cfg: assert property (p_oe_cfg) else $error("enable moved alone");
  a_pin_owned: assert property (p_pin_owned) else $error("undriven pin moved");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule

bind channel_timer_array channel_timer_array_checker #(.NCH(NCH)) u_checker (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_ch_pin(o_ch_pin), .o_ch_pin_oe(o_ch_pin_oe), .o_irq(o_irq)
);

// *** tb/ext_signals.sv ***
`timescale 1ns/1ps
module ext_signals (
  // Clock
  input wire logic i_clk,
  // Driven lines
  output logic [15:0] o_pins,
  output logic [1:0] o_ext
);
  initial begin
    o_pins = 16'h0000;
    o_ext = 2'h0;
  end
  task automatic drive(input logic [15:0] v);
    @(posedge i_clk);
    o_pins <= v;
  endtask
  // Gap sets how slowly the source counts
  task automatic pulses(input int idx, input int n, input int gap);
    repeat (n) begin
      @(posedge i_clk);
      o_ext[idx] <= 1'b1;
      repeat (gap) @(posedge i_clk);
      o_ext[idx] <= 1'b0;
      repeat (gap) @(posedge i_clk);
    end
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "ctc_consts.svh"
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wait_req;
  logic [15:0] pin_in;
  logic [15:0] pin;
  logic [15:0] oe;
  logic [1:0] ext;
  logic aux = 1'b0;
  logic irq;
  int errors = 0;
  int tests_run = 0;
  always #5 i_clk = ~i_clk;
  ext_signals u_ext (.i_clk(i_clk), .o_pins(pin_in), .o_ext(ext));
  channel_timer_array #(.NCH(16)) DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_ch_pin((pin_in & ~oe) | (pin & oe)),
    .o_ch_pin(pin), .o_ch_pin_oe(oe), .i_ext_count(ext),
    .i_aux_timer_six_ovf(aux), .o_irq(irq)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    // Waitrequest and read data are sampled as the edge sees them
    do @(posedge i_clk); while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic get(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask
  // Steps the aux-clocked timer once per pulse
  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_clk) aux <= 1'b1;
      @(posedge i_clk) aux <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
    @(negedge i_clk);
  endtask
  task automatic t_regs;
    get(`OFS_TCFG0, 32'h0000_0000);
    put(`OFS_TREL1, 32'hFFFF_ABCD);
    get(`OFS_TREL1, 32'h0000_ABCD);
    put(8'h30, 32'h0000_FFFF);
    get(8'h30, 32'h0000_0000);
  endtask
  task automatic t_capture;
    put(`OFS_TCNT0, 32'h0000_1234);
    for (int n = 1; n < 4; n++) put(`OFS_CH_CFG + 8'(4 * n), 32'(n));
    u_ext.drive(16'h000E);
    repeat (8) @(posedge i_clk);
    get(`OFS_IRQ_STAT, 32'h0000_000A);
    get(`OFS_CH_VAL + 8'h04, 32'h0000_1234);
    put(`OFS_IRQ_CLR, 32'h0000_000F);
    put(`OFS_TCNT0, 32'h0000_2222);
    u_ext.drive(16'h0000);
    repeat (8) @(posedge i_clk);
    get(`OFS_IRQ_STAT, 32'h0000_000C);
    get(`OFS_CH_VAL + 8'h0C, 32'h0000_2222);
  endtask
  task automatic t_compare;
    put(`OFS_IRQ_CLR, 32'h0003_FFFF);
    put(`OFS_TREL0, 32'h0000_FFF0);
    put(`OFS_TCNT0, 32'h0000_FFF0);
    for (int n = 4; n < 8; n++) begin
      put(`OFS_CH_VAL + 8'(4 * n), 32'h0000_FFF2);
      put(`OFS_CH_CFG + 8'(4 * n), 32'(n));
    end
    put(`OFS_TCFG0, 32'h0000_000E);
    step(2);
    check({16'h0000, pin}, 32'h0000_00A0);
    get(`OFS_IRQ_STAT, 32'h0000_00F0);
    put(`OFS_IRQ_CLR, 32'h0000_00F0);
    for (int n = 4; n < 8; n++) put(`OFS_CH_VAL + 8'(4 * n), 32'h0000_FFF5);
    step(3);
    check({16'h0000, pin}, 32'h0000_0080);
    get(`OFS_IRQ_STAT, 32'h0000_0030);
    step(11);
    check({16'h0000, pin}, 32'h0000_0000);
    get(`OFS_IRQ_STAT, 32'h0001_0030);
    put(`OFS_IRQ_CLR, 32'h0003_FFFF);
    step(5);
    check({16'h0000, pin}, 32'h0000_00A0);
    get(`OFS_IRQ_STAT, 32'h0000_00F0);
    get(`OFS_TCNT0, 32'h0000_FFF5);
    check({16'h0000, oe}, 32'h0000_00A0);
  endtask
  task automatic t_irq;
    put(`OFS_IRQ_EN, 32'h0000_0010);
    @(negedge i_clk) check({31'h0, irq}, 32'h1);
    put(`OFS_IRQ_EN, 32'h0000_0008);
    @(negedge i_clk) check({31'h0, irq}, 32'h0);
    put(`OFS_IRQ_SET, 32'h0000_0008);
    @(negedge i_clk) check({31'h0, irq}, 32'h1);
    put(`OFS_IRQ_CLR, 32'h0000_0008);
    @(negedge i_clk) check({31'h0, irq}, 32'h0);
  endtask
  task automatic t_pair_single;
    put(`OFS_CH_VAL + 8'h24, 32'h0000_FFF7);
    put(`OFS_CH_CFG + 8'h24, 32'h0000_0008);
    put(`OFS_CH_VAL + 8'h04, 32'h0000_FFF9);
    put(`OFS_CH_CFG + 8'h04, 32'h0000_0004);
    put(`OFS_CH_VAL + 8'h28, 32'h0000_FFF7);
    put(`OFS_CH_CFG + 8'h28, 32'h0000_0025);
    step(2);
    check({16'h0000, pin & 16'h0600}, 32'h0000_0600);
    step(2);
    check({16'h0000, pin & 16'h0600}, 32'h0000_0400);
    step(14);
    check({16'h0000, pin & 16'h0600}, 32'h0000_0600);
  endtask
  task automatic t_ext_stag;
    put(`OFS_TCNT1, 32'h0000_0000);
    put(`OFS_TCFG1, 32'h0000_000F);
    u_ext.pulses(1, 3, 4);
    u_ext.pulses(1, 2, 20);
    get(`OFS_TCNT1, 32'h0000_0005);
    put(`OFS_TCFG1, 32'h0000_0000);
    put(`OFS_TCNT1, 32'h0000_0000);
    put(`OFS_STAG, 32'h0000_0001);
    put(`OFS_TCFG1, 32'h0000_0008);
    repeat (80) @(posedge i_clk);
    put(`OFS_TCFG1, 32'h0000_0000);
    bus(1'b0, `OFS_TCNT1, 32'h0000_0000);
    check({31'h0, q inside {[32'd10:32'd11]}}, 32'h1);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_capture();
    t_compare();
    t_irq();
    t_pair_single();
    t_ext_stag();
    complete_run();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule
